// >>> src/aimc_params.svh
// Purpose: Constants of the analog input conditioning block
// Assumes: 20 MHz clock, one word per APB register
// Notes:   Each channel owns a 16-byte register window
`ifndef AIMC_PARAMS_SVH
`define AIMC_PARAMS_SVH
`define AIMC_REG_CFG      4'h0
`define AIMC_REG_THR      4'h4
`define AIMC_REG_ALIGN    4'h8
`define AIMC_REG_VALUE    4'hc
`define AIMC_CH_LSB       4
`define AIMC_CFG_BIP_BIT  3
`define AIMC_CFG_USER_BIT 4
`define AIMC_CFG_SAVE_BIT 8
`define AIMC_CFG_ALN_BIT  9
`define AIMC_FILT_MAX     3'h6
`define AIMC_FRAC         8
`define AIMC_STD_MAX      16'sh2710
`define AIMC_BIP_MIN      16'shd8f0
`define AIMC_UNI_SPAN     18'sh02710
`define AIMC_BIP_SPAN     18'sh04e20
`define AIMC_OFF_MAX      17'sh005dc
`define AIMC_OFF_MIN      17'sh1fa24
`define AIMC_T_NS         5000000
`define AIMC_CLK_NS       50
`endif

// >>> src/aimc_pkg.sv
// Purpose: Types of the analog input conditioning block
// Assumes: Nothing beyond the constants header
// Notes:   Shared by the block and its bench
package aimc_pkg;
    typedef enum logic {AIMC_IDLE, AIMC_SCAN} aimc_state_type;
    typedef logic signed [15:0] aimc_word_type;
    typedef logic [2:0]         aimc_filt_type;
endpackage : aimc_pkg

// >>> src/aimc_cond.sv
// Purpose: Per-channel alignment, first order filter and scaling
// Assumes: Raw samples already in standardized counts, same clock domain
// Notes:   One APB wait state; one channel processed per clock each period
`include "aimc_params.svh"
module aimc_cond #(
    parameter int CHANNELS   = 8,
    parameter int CW         = $clog2(CHANNELS),
    parameter int PERIOD_CYC = `AIMC_T_NS / `AIMC_CLK_NS
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Raw samples from acquisition
    input  wire logic                  raw_valid,
    input  wire logic [CW-1:0]         raw_chan,
    input  wire aimc_pkg::aimc_word_type raw_data,
    // Conditioned values to the application
    output logic                       out_valid,
    output logic [CW-1:0]              out_chan,
    output aimc_pkg::aimc_word_type    out_value
);
    import aimc_pkg::*;

    function automatic aimc_word_type sat16(input logic signed [35:0] v);
        if (v > 36'sh000007fff)
            return 16'sh7fff;
        else if (v < -36'sh000008000)
            return 16'sh8000;
        return v[15:0];
    endfunction : sat16

    function automatic aimc_word_type clamp_off(input logic signed [16:0] v);
        if (v > `AIMC_OFF_MAX)
            return 16'(`AIMC_OFF_MAX);
        else if (v < `AIMC_OFF_MIN)
            return 16'(`AIMC_OFF_MIN);
        return v[15:0];
    endfunction : clamp_off

    aimc_filt_type            filt     [CHANNELS];
    logic                     bip      [CHANNELS];
    logic                     user     [CHANNELS];
    logic                     aligned  [CHANNELS];
    logic                     first    [CHANNELS];
    logic                     fresh    [CHANNELS];
    aimc_word_type            thr_lo   [CHANNELS];
    aimc_word_type            thr_hi   [CHANNELS];
    aimc_word_type            off      [CHANNELS];
    aimc_word_type            desired  [CHANNELS];
    aimc_word_type            raw_last [CHANNELS];
    aimc_word_type            value    [CHANNELS];
    logic signed [23:0]       st       [CHANNELS];
    aimc_state_type           state;
    logic [31:0]              cnt;
    logic                     tick;
    logic [CW-1:0]            scan_ch;

    // Register decode
    wire logic                acc     = psel & penable & ~pready;
    wire logic [CW-1:0]       a_ch    = paddr[`AIMC_CH_LSB +: CW];
    wire logic [3:0]          a_reg   = paddr[3:0];
    wire logic                hit     = (paddr[11:`AIMC_CH_LSB+CW] == '0)
                                        && (32'(a_ch) < CHANNELS);
    wire logic                wr      = acc & pwrite & hit;
    wire logic                wr_cfg  = wr && a_reg == `AIMC_REG_CFG;
    wire logic                wr_thr  = wr && a_reg == `AIMC_REG_THR;
    wire logic                wr_aln  = wr && a_reg == `AIMC_REG_ALIGN;
    wire logic                wr_save = wr_cfg & pwdata[`AIMC_CFG_SAVE_BIT];
    // Settings above six are held at the strongest filter
    wire aimc_filt_type       w_filt  = (pwdata[2:0] > `AIMC_FILT_MAX) ?
                                        `AIMC_FILT_MAX : pwdata[2:0];
    wire logic [31:0]         rd_word =
        (a_reg == `AIMC_REG_CFG)   ? {22'h0, aligned[a_ch], 4'h0, user[a_ch],
                                      bip[a_ch], filt[a_ch]} :
        (a_reg == `AIMC_REG_THR)   ? {thr_hi[a_ch], thr_lo[a_ch]} :
        (a_reg == `AIMC_REG_ALIGN) ? {desired[a_ch], off[a_ch]} :
        (a_reg == `AIMC_REG_VALUE) ? {{16{value[a_ch][15]}}, value[a_ch]} :
        32'h0;
    wire logic                scan_go = state == AIMC_SCAN;

    // Datapath for the channel under scan: align, filter, scale
    wire aimc_filt_type       c_filt  = filt[scan_ch];
    wire logic signed [16:0]  c_diff  = 17'(raw_last[scan_ch]) - 17'(off[scan_ch]);
    wire aimc_word_type       aln     = sat16(36'(c_diff));
    wire logic signed [23:0]  x       = {aln, 8'h00};
    wire logic signed [24:0]  f_err   = 25'(x) - 25'(st[scan_ch]);
    wire logic [2:0]          f_k     = c_filt + 3'h1;
    // Alpha = 1 - 2^-(setting+1): 0.75 .. 0.992
    wire logic signed [24:0]  f_step  = f_err >>> f_k;
    wire logic signed [23:0]  st_new  = (first[scan_ch] || c_filt == 3'h0) ?
                                        x : 24'(25'(st[scan_ch]) + f_step);
    wire aimc_word_type       flt     = st_new[23:`AIMC_FRAC];
    wire aimc_word_type       rmin    = bip[scan_ch] ? `AIMC_BIP_MIN : 16'sh0000;
    wire logic signed [17:0]  span    = bip[scan_ch] ? `AIMC_BIP_SPAN :
                                        `AIMC_UNI_SPAN;
    wire logic signed [16:0]  s_pos   = 17'(flt) - 17'(rmin);
    wire logic signed [16:0]  s_rng   = 17'(thr_hi[scan_ch]) - 17'(thr_lo[scan_ch]);
    wire logic signed [33:0]  s_num   = 34'(s_pos) * 34'(s_rng);
    wire logic signed [33:0]  s_q     = s_num / 34'(span);
    wire logic signed [35:0]  s_usr   = 36'(s_q) + 36'(thr_lo[scan_ch]);
    // Standardized mode passes counts through: 0..10000 or -10000..10000
    wire aimc_word_type       res     = user[scan_ch] ? sat16(s_usr) : flt;

    // APB slave: answer one cycle into the access phase
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & ~hit;
            if (acc)
                prdata <= hit ? rd_word : 32'h0;
        end
    end

    // Settings; a write can land while the channel runs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                filt[i]    <= 3'h0;
                bip[i]     <= 1'b0;
                user[i]    <= 1'b0;
                aligned[i] <= 1'b0;
                first[i]   <= 1'b1;
                thr_lo[i]  <= 16'sh0000;
                thr_hi[i]  <= `AIMC_STD_MAX;
                off[i]     <= 16'sh0000;
                desired[i] <= 16'sh0000;
            end
        end
        else
        begin
            // Restart waits for a real sample, so no start-up transient
            // Restart wins over the scan's clear in the same cycle
            if (scan_go && fresh[scan_ch])
                first[scan_ch] <= 1'b0;
            if (wr_cfg)
            begin
                filt[a_ch] <= w_filt;
                bip[a_ch]  <= pwdata[`AIMC_CFG_BIP_BIT];
                user[a_ch] <= pwdata[`AIMC_CFG_USER_BIT];
                if (w_filt != filt[a_ch])
                    first[a_ch] <= 1'b1;
            end
            if (wr_save)
            begin
                off[a_ch]     <= clamp_off(17'(raw_last[a_ch]) - 17'(desired[a_ch]));
                aligned[a_ch] <= 1'b1;
            end
            else if (wr_aln)
            begin
                off[a_ch]     <= clamp_off(17'($signed(pwdata[15:0])));
                desired[a_ch] <= pwdata[31:16];
                aligned[a_ch] <= pwdata[15:0] != 16'h0;
            end
            if (wr_thr)
            begin
                thr_lo[a_ch] <= pwdata[15:0];
                thr_hi[a_ch] <= pwdata[31:16];
            end
        end
    end

    // Latest raw sample per channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                raw_last[i] <= 16'sh0000;
                fresh[i]    <= 1'b0;
            end
        end
        else
        begin
            // A sample landing with the scan still counts as fresh
            if (scan_go)
                fresh[scan_ch] <= 1'b0;
            if (raw_valid)
            begin
                raw_last[raw_chan] <= raw_data;
                fresh[raw_chan]    <= 1'b1;
            end
        end
    end

    // Module cycle timer; cycle length does not touch the filter law
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= cnt == 32'(PERIOD_CYC - 1);
            cnt  <= (cnt == 32'(PERIOD_CYC - 1)) ? 32'h0 : cnt + 32'h1;
        end
    end

    // Scan: one channel per clock after each tick
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= AIMC_IDLE;
            scan_ch   <= '0;
            out_valid <= 1'b0;
            out_chan  <= '0;
            out_value <= 16'sh0000;
            for (int i = 0; i < CHANNELS; i++)
            begin
                st[i]    <= 24'sh000000;
                value[i] <= 16'sh0000;
            end
        end
        else
        begin
            out_valid <= scan_go;
            unique case (state)
                AIMC_IDLE:
                begin
                    scan_ch <= '0;
                    if (tick)
                        state <= AIMC_SCAN;
                end
                AIMC_SCAN:
                begin
                    st[scan_ch]    <= st_new;
                    value[scan_ch] <= res;
                    out_chan       <= scan_ch;
                    out_value      <= res;
                    scan_ch        <= scan_ch + 1'b1;
                    if (32'(scan_ch) == CHANNELS - 1)
                        state <= AIMC_IDLE;
                end
            endcase
        end
    end

    sequence seq_save;
        wr_save ##1 1'b1;
    endsequence

    AST_FILT_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        scan_go && c_filt == 3'h0 |-> flt == aln)
        else $error("Unfiltered channel differs from aligned sample");
    AST_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
        scan_go && first[scan_ch] |-> flt == aln)
        else $error("Filter did not restart from the sample");
    AST_OFF_LIM: assert property (@(posedge clk) disable iff (!rst_n)
        off[a_ch] <= 16'sh05dc && off[a_ch] >= -16'sh05dc)
        else $error("Alignment offset out of limit");
    AST_STD: assert property (@(posedge clk) disable iff (!rst_n)
        scan_go && !user[scan_ch] |=> out_valid && out_value == $past(flt))
        else $error("Standardized value not passed through");
    AST_USER_LO: assert property (@(posedge clk) disable iff (!rst_n)
        scan_go && user[scan_ch] && flt == rmin |=> out_value == $past(thr_lo[scan_ch]))
        else $error("Range minimum not mapped to lower threshold");
    AST_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
        tick |-> $past(cnt) == 32'(PERIOD_CYC - 1) ##1 scan_go)
        else $error("Module cycle tick misplaced");
    AST_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid |-> $past(scan_go) && out_chan == $past(scan_ch))
        else $error("Output without a scan step");
    AST_SAVE: assert property (@(posedge clk) disable iff (!rst_n)
        seq_save |-> aligned[$past(a_ch)])
        else $error("Saved alignment not reported");
    AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cfg && w_filt != filt[a_ch] |=> first[$past(a_ch)] && filt[$past(a_ch)] == $past(w_filt))
        else $error("Filter change not taken");
    AST_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
        scan_go && first[scan_ch] && !fresh[scan_ch] |=> first[$past(scan_ch)])
        else $error("Filter restarted without a new sample");
    AST_USER_HI: assert property (@(posedge clk) disable iff (!rst_n)
        scan_go && user[scan_ch] && flt == `AIMC_STD_MAX |=> out_value == $past(thr_hi[scan_ch]))
        else $error("Range maximum not mapped to upper threshold");
    AST_SAT: assert property (@(posedge clk) disable iff (!rst_n)
        scan_go && user[scan_ch] && s_usr > 36'sh000007fff |=> out_value == 16'sh7fff)
        else $error("User value not saturated");
    AST_ALN_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        wr_aln |=> filt[$past(a_ch)] == $past(filt[a_ch]) && bip[$past(a_ch)] == $past(bip[a_ch])
            && user[$past(a_ch)] == $past(user[a_ch]))
        else $error("Alignment write touched the channel modes");
endmodule : aimc_cond

// >>> testbench/aimc_app.sv
// Purpose: Controller application model, APB master of the block
// Assumes: Slave answers with pready, bench timeout cuts a hang
// Notes:   Released bus shows inverted data, never the last value
module aimc_app (
    // Clock
    input  wire logic        clk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // Thresholds are handed over as one 32-bit word, both 16-bit halves at once
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : aimc_app

// >>> testbench/aimc_cond_tb.sv
// Purpose: Self-checking bench of the conditioning block
// Assumes: Short period of 40 cycles, eight channels
// Notes:   Values are checked on the output stream and over APB
module aimc_cond_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aimc_pkg::*;

    logic               clk;
    logic               rst_n;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
    logic               raw_valid;
    logic [2:0]         raw_chan;
    aimc_word_type      raw_data;
    logic               out_valid;
    logic [2:0]         out_chan;
    aimc_word_type      out_value;
    logic [31:0]        rd;
    logic               err;
    int                 miscompares = 0;
    int                 n_checks = 0;
    int                 cyc = 0;

    aimc_cond #(.CHANNELS(8), .PERIOD_CYC(40)) aimc_cond_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .raw_valid(raw_valid), .raw_chan(raw_chan),
        .raw_data(raw_data), .out_valid(out_valid), .out_chan(out_chan),
        .out_value(out_value));

    aimc_app aimc_app_inst (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task close_out;
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [31:0] d);
        aimc_app_inst.xfer(1'b1, a, d, rd, err);
    endtask : wr

    task rdk(input logic [11:0] a, input logic [31:0] exp);
        aimc_app_inst.xfer(1'b0, a, 32'h00000000, rd, err);
        chk(rd, exp);
    endtask : rdk

    task raw(input logic [2:0] ch, input logic [15:0] v);
        @(posedge clk);
        raw_valid <= 1'b1;
        raw_chan  <= ch;
        raw_data  <= v;
        @(posedge clk);
        raw_valid <= 1'b0;
        raw_chan  <= ~ch;
        raw_data  <= ~v;
    endtask : raw

    // Wait for n outputs of one channel, judge the last one
    task out_is(input logic [2:0] ch, input int n, input logic [15:0] exp);
        repeat (n)
        begin
            do @(posedge clk); while (!(out_valid === 1'b1 && out_chan === ch));
        end
        chk({16'h0000, out_value}, {16'h0000, exp});
    endtask : out_is

    task t_reset_and_map;
        rdk(12'h000, 32'h00000000);
        rdk(12'h004, 32'h27100000);
        aimc_app_inst.xfer(1'b0, 12'h100, 32'h00000000, rd, err);
        chk({31'h0, err}, 32'h00000001);
        chk(rd, 32'h00000000);
    endtask : t_reset_and_map

    task t_filter_codes;
        for (int k = 0; k < 8; k++)
        begin
            wr(12'h000, k);
            rdk(12'h000, (k == 7) ? 32'h00000006 : k);
        end
    endtask : t_filter_codes

    task t_filter_law;
        wr(12'h000, 32'h00000001);
        raw(3'h0, 16'h0000);
        out_is(3'h0, 2, 16'h0000);
        raw(3'h0, 16'h0fa0);
        out_is(3'h0, 1, 16'h03e8);
        out_is(3'h0, 1, 16'h06d6);
        wr(12'h000, 32'h00000000);
        out_is(3'h0, 2, 16'h0fa0);
    endtask : t_filter_law

    task t_user_scale;
        wr(12'h004, 32'h25800c80);
        wr(12'h000, 32'h00000010);
        raw(3'h0, 16'h2710);
        out_is(3'h0, 2, 16'h2580);
        wr(12'h000, 32'h00000018);
        raw(3'h0, 16'hd8f0);
        out_is(3'h0, 2, 16'h0c80);
        raw(3'h0, 16'h0000);
        out_is(3'h0, 1, 16'h1900);
        wr(12'h000, 32'h00000008);
        raw(3'h0, 16'hd8f0);
        out_is(3'h0, 2, 16'hd8f0);
        wr(12'h000, 32'h00000010);
        raw(3'h0, 16'h1388);
        out_is(3'h0, 2, 16'h1900);
        wr(12'h000, 32'h00000000);
        out_is(3'h0, 2, 16'h1388);
        wr(12'h004, 32'h7fff8000);
        wr(12'h000, 32'h00000010);
        raw(3'h0, 16'h2af8);
        out_is(3'h0, 2, 16'h7fff);
        wr(12'h000, 32'h00000000);
    endtask : t_user_scale

    task t_align;
        rdk(12'h020, 32'h00000000);
        wr(12'h028, 32'h000007d0);
        rdk(12'h028, 32'h000005dc);
        rdk(12'h020, 32'h00000200);
        raw(3'h2, 16'h1388);
        raw(3'h0, 16'h1388);
        out_is(3'h2, 2, 16'h0dac);
        out_is(3'h0, 1, 16'h1388);
        rdk(12'h02c, 32'h00000dac);
        wr(12'h028, 32'h0000f830);
        rdk(12'h028, 32'h0000fa24);
        wr(12'h028, 32'h12c00000);
        rdk(12'h020, 32'h00000000);
        wr(12'h020, 32'h00000100);
        rdk(12'h028, 32'h12c000c8);
        rdk(12'h020, 32'h00000200);
        out_is(3'h2, 2, 16'h12c0);
    endtask : t_align

    initial
    begin
        rst_n     = 1'b0;
        raw_valid = 1'b0;
        raw_chan  = 3'h0;
        raw_data  = 16'sh0000;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_and_map();
        t_filter_codes();
        t_filter_law();
        t_user_scale();
        t_align();
        close_out();
    end
endmodule : aimc_cond_tb
